// file: opd_decoder.sv
`timescale 1ns/1ps
`include "opd_params.svh"

module opd_decoder
  import opd_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic fetchReq_q,
  output logic [ADDR_W-1:0] fetchAddr_q,
  input wire logic fetchValid,
  input wire logic [15:0] fetchWord,
  input wire logic accZero,
  input wire logic accNeg,
  input wire logic overflowFlag,
  input wire logic carryFlag,
  input wire logic testControlFlag,
  input wire logic branchInputPin,
  output logic execPulse_q,
  output opd_class_t opClass_q,
  output logic [15:0] operandWord_q,
  output logic [7:0] shortConstant_q,
  output logic [3:0] shiftCount_q,
  output logic [3:0] probeIndex_q,
  output logic [2:0] auxSelect_q,
  output logic [1:0] compareKind_q,
  output logic [3:0] flagSelect_q,
  output logic useTempShift_q,
  output logic condMet_q,
  output logic [2:0] cycleCost_q
);

  generate
    if (ADDR_W < 1 || ADDR_W > 16) begin : gBadWidth
      $error("ADDR_W must be 1 to 16");
    end
  endgenerate

  // ------------------------------------------------------------
  // Decode functions
  // ------------------------------------------------------------
  function automatic opd_class_t classOf(input logic [15:0] w);
    opd_class_t c;
    c = OPD_NONE;
    if (w[15:10] == 6'b111000) begin
      c = OPD_COND_BRANCH;
    end else if (w[15:10] == 6'b111010) begin
      c = OPD_COND_CALL;
    end else if (w[15:12] == 4'b0100) begin
      c = OPD_PROBE;
    end else if (w[15:12] == 4'b0001) begin
      c = OPD_ACC_SHIFTED;
    end else if (w[15:4] == 12'hbe4 && (w[3:0] inside {4'h4, 4'h0, 4'he, 4'h2, 4'h6, 4'ha, 4'hc})) begin
      c = OPD_FLAG_CLEAR;
    end else if (w == 16'hbe22) begin
      c = OPD_IDLE;
    end else if (w == 16'hbe30) begin
      c = OPD_CALL_INDIRECT;
    end else if (w[15:5] == 11'b10111110011) begin
      c = OPD_SW_INT;
    end else if (w[15:2] == 14'b10111111010001) begin
      c = OPD_AUX_COMPARE;
    end else if (w[15:3] == 13'b1011111100001) begin
      c = OPD_AUX_LONG;
    end else if (w[15:4] == 12'hbf8) begin
      c = OPD_ACC_LONG;
    end else if (w[15:9] == 7'b1011110) begin
      c = OPD_PAGE_IMM;
    end else if (w[15:11] == 5'b10110) begin
      c = OPD_AUX_SHORT;
    end else if (w[15:11] == 5'b00000) begin
      c = OPD_AUX_DIRECT;
    end else begin
      unique case (w[15:8])
        8'h6f: c = OPD_REG_PROBE;
        8'ha8: c = OPD_BLK_DD_SRC;
        8'ha9: c = OPD_BLK_DD_DST;
        8'ha5: c = OPD_BLK_PD;
        8'h7a: c = OPD_CALL;
        8'h77: c = OPD_DATA_COPY;
        8'haf: c = OPD_PORT_IN;
        8'h6a: c = OPD_ACC_HIGH_ZERO_LOW;
        8'hb9: c = OPD_ACC_SHORT;
        8'h69: c = OPD_ACC_LOW;
        8'h6b: c = OPD_ACC_TEMP_SHIFT;
        8'h0d: c = OPD_PAGE_MEM;
        8'h0e: c = OPD_STATUS_ZERO;
        8'h0f: c = OPD_STATUS_ONE;
        8'h73: c = OPD_TEMP_LOAD;
        8'h70: c = OPD_TEMP_LOAD_ACC;
        default: c = OPD_NONE;
      endcase
    end
    return c;
  endfunction

  function automatic opd_decode_t decodeWord(input logic [15:0] w);
    opd_decode_t d;
    d.cls = classOf(w);
    d.conditional = (d.cls == OPD_COND_BRANCH) || (d.cls == OPD_COND_CALL);
    d.twoWords = d.conditional || (d.cls inside {OPD_BLK_DD_SRC, OPD_BLK_DD_DST, OPD_BLK_PD, OPD_CALL,
      OPD_PORT_IN, OPD_ACC_LONG, OPD_AUX_LONG});
    unique case (d.cls)
      OPD_COND_BRANCH, OPD_COND_CALL, OPD_CALL, OPD_CALL_INDIRECT, OPD_SW_INT: d.costTaken = `OPD_COST_FOUR;
      OPD_BLK_DD_SRC, OPD_BLK_DD_DST, OPD_BLK_PD: d.costTaken = `OPD_COST_THREE;
      OPD_PORT_IN, OPD_ACC_LONG, OPD_AUX_DIRECT, OPD_AUX_SHORT, OPD_AUX_LONG, OPD_PAGE_MEM, OPD_PAGE_IMM,
        OPD_STATUS_ZERO, OPD_STATUS_ONE: d.costTaken = `OPD_COST_TWO;
      default: d.costTaken = `OPD_COST_ONE;
    endcase
    d.costNotTaken = d.conditional ? `OPD_COST_TWO : d.costTaken;
    return d;
  endfunction

  function automatic logic condCheck(input logic [15:0] w, input logic [3:0] actual, input logic flagNow,
                                     input logic pinNow);
    logic maskOk;
    logic selOk;
    maskOk = (w[3:0] == 4'h0) ? 1'b1 : |(w[3:0] & ~(actual ^ w[7:4]));
    unique case (w[9:8])
      2'b00: selOk = ~pinNow;
      2'b01: selOk = flagNow;
      2'b10: selOk = ~flagNow;
      2'b11: selOk = 1'b1;
    endcase
    return maskOk & selOk;
  endfunction

  // ------------------------------------------------------------
  // Branch input pin synchroniser
  // ------------------------------------------------------------
  logic pinS1_q, pinS2_q, pinS3_q, pinStable_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pinS1_q <= 1'b1;
      pinS2_q <= 1'b1;
      pinS3_q <= 1'b1;
      pinStable_q <= 1'b1;
    end else begin
      pinS1_q <= branchInputPin;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      if (pinS2_q == pinS3_q) begin
        pinStable_q <= pinS3_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  logic run_q;
  logic [ADDR_W-1:0] pc_q;
  logic [31:0] count_q;
  logic lastTaken_q;
  opd_state_t state_q;
  logic wbReq;
  logic wbWrite;

  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWrite = wbReq & wb_we_i;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0000_0000;
      if (wbReq && !wb_we_i) begin
        unique case (wb_adr_i)
          `OPD_REG_CTRL: wb_dat_o[`OPD_CTRL_RUN_BIT] <= run_q;
          `OPD_REG_PC: wb_dat_o[ADDR_W-1:0] <= pc_q;
          `OPD_REG_STATUS: begin
            wb_dat_o[`OPD_STAT_CLASS_LSB +: 5] <= opClass_q;
            wb_dat_o[`OPD_STAT_COST_LSB +: 3] <= cycleCost_q;
            wb_dat_o[`OPD_STAT_TAKEN_BIT] <= lastTaken_q;
            wb_dat_o[`OPD_STAT_BUSY_BIT] <= (state_q != OPD_ST_HALT);
          end
          `OPD_REG_COUNT: wb_dat_o <= count_q;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= `OPD_CTRL_RESET;
    end else if (wbWrite && wb_adr_i == `OPD_REG_CTRL && wb_sel_i[0]) begin
      run_q <= wb_dat_i[`OPD_CTRL_RUN_BIT];
    end
  end

  // ------------------------------------------------------------
  // Fetch and sequencing
  // ------------------------------------------------------------
  opd_decode_t dec;
  opd_decode_t cur_q;
  logic [15:0] first_q;
  logic [2:0] stall_q;
  logic taken;
  logic [15:0] pcWriteData;

  assign dec = decodeWord(fetchWord);
  assign taken = ~cur_q.conditional |
                 condCheck(first_q, {accZero, accNeg, overflowFlag, carryFlag}, testControlFlag, pinStable_q);
  assign pcWriteData = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'(16'(pc_q) >> 8), wb_sel_i[0] ? wb_dat_i[7:0] : 8'(pc_q)};

  // Run is sampled only between instructions so a half-fetched pair never splits
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= OPD_ST_HALT;
      fetchReq_q <= 1'b0;
      stall_q <= 3'h0;
    end else begin
      unique case (state_q)
        OPD_ST_HALT: begin
          if (run_q) begin
            state_q <= OPD_ST_FETCH1;
            fetchReq_q <= 1'b1;
          end
        end
        OPD_ST_FETCH1: begin
          if (fetchValid) begin
            state_q <= dec.twoWords ? OPD_ST_FETCH2 : OPD_ST_EXEC;
            fetchReq_q <= dec.twoWords;
          end
        end
        OPD_ST_FETCH2: begin
          if (fetchValid) begin
            state_q <= OPD_ST_EXEC;
            fetchReq_q <= 1'b0;
          end
        end
        OPD_ST_EXEC: begin
          stall_q <= (taken ? cur_q.costTaken : cur_q.costNotTaken) - 3'h1;
          state_q <= OPD_ST_STALL;
        end
        OPD_ST_STALL: begin
          if (stall_q == 3'h0) begin
            state_q <= run_q ? OPD_ST_FETCH1 : OPD_ST_HALT;
            fetchReq_q <= run_q;
          end else begin
            stall_q <= stall_q - 3'h1;
          end
        end
      endcase
    end
  end

  // Program counter; software may move it only while halted
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= ADDR_W'(`OPD_PC_RESET);
    end else if (state_q == OPD_ST_HALT) begin
      if (wbWrite && wb_adr_i == `OPD_REG_PC) begin
        pc_q <= pcWriteData[ADDR_W-1:0];
      end
    end else if ((state_q == OPD_ST_FETCH1 || state_q == OPD_ST_FETCH2) && fetchValid) begin
      pc_q <= pc_q + ADDR_W'(1);
    end else if (state_q == OPD_ST_EXEC && taken &&
                 (cur_q.cls == OPD_COND_BRANCH || cur_q.cls == OPD_CALL || cur_q.cls == OPD_COND_CALL)) begin
      pc_q <= operandWord_q[ADDR_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fetchAddr_q <= ADDR_W'(`OPD_PC_RESET);
    end else begin
      fetchAddr_q <= pc_q;
    end
  end

  // ------------------------------------------------------------
  // Captured instruction and decoded fields
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur_q <= '{cls: OPD_NONE, twoWords: 1'b0, conditional: 1'b0, costTaken: 3'h1, costNotTaken: 3'h1};
      first_q <= 16'h0000;
      operandWord_q <= 16'h0000;
    end else if (state_q == OPD_ST_FETCH1 && fetchValid) begin
      cur_q <= dec;
      first_q <= fetchWord;
      operandWord_q <= 16'h0000;
    end else if (state_q == OPD_ST_FETCH2 && fetchValid) begin
      operandWord_q <= fetchWord;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      execPulse_q <= 1'b0;
      opClass_q <= OPD_NONE;
      shortConstant_q <= 8'h00;
      shiftCount_q <= 4'h0;
      probeIndex_q <= 4'h0;
      auxSelect_q <= 3'h0;
      compareKind_q <= 2'h0;
      flagSelect_q <= 4'h0;
      useTempShift_q <= 1'b0;
      condMet_q <= 1'b0;
      cycleCost_q <= 3'h0;
      lastTaken_q <= 1'b0;
    end else begin
      execPulse_q <= (state_q == OPD_ST_EXEC);
      if (state_q == OPD_ST_EXEC) begin
        opClass_q <= cur_q.cls;
        shortConstant_q <= first_q[7:0];
        shiftCount_q <= (cur_q.cls == OPD_ACC_LONG) ? first_q[3:0] : first_q[11:8];
        probeIndex_q <= first_q[11:8];
        auxSelect_q <= (cur_q.cls == OPD_AUX_LONG) ? first_q[2:0] : first_q[10:8];
        compareKind_q <= first_q[1:0];
        flagSelect_q <= first_q[3:0];
        useTempShift_q <= (cur_q.cls == OPD_REG_PROBE) || (cur_q.cls == OPD_ACC_TEMP_SHIFT);
        condMet_q <= taken;
        lastTaken_q <= taken;
        cycleCost_q <= taken ? cur_q.costTaken : cur_q.costNotTaken;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= 32'h0000_0000;
    end else if (wbWrite && wb_adr_i == `OPD_REG_COUNT) begin
      count_q <= 32'h0000_0000;
    end else if (state_q == OPD_ST_EXEC) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

endmodule

// file: opd_params.svh
`ifndef OPD_PARAMS_SVH
`define OPD_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OPD_REG_CTRL 8'h00
`define OPD_REG_PC 8'h04
`define OPD_REG_STATUS 8'h08
`define OPD_REG_COUNT 8'h0c

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define OPD_CTRL_RUN_BIT 0
`define OPD_CTRL_RESET 1'h0
`define OPD_PC_RESET 16'h0000
`define OPD_STAT_CLASS_LSB 0
`define OPD_STAT_COST_LSB 8
`define OPD_STAT_TAKEN_BIT 12
`define OPD_STAT_BUSY_BIT 16

// ------------------------------------------------------------
// Cycle costs
// ------------------------------------------------------------
`define OPD_COST_ONE 3'h1
`define OPD_COST_TWO 3'h2
`define OPD_COST_THREE 3'h3
`define OPD_COST_FOUR 3'h4

`endif

// file: opd_pkg.sv
package opd_pkg;

  typedef enum logic [4:0] {
    OPD_NONE,
    OPD_COND_BRANCH,
    OPD_PROBE,
    OPD_REG_PROBE,
    OPD_BLK_DD_SRC,
    OPD_BLK_DD_DST,
    OPD_BLK_PD,
    OPD_CALL_INDIRECT,
    OPD_CALL,
    OPD_COND_CALL,
    OPD_FLAG_CLEAR,
    OPD_AUX_COMPARE,
    OPD_DATA_COPY,
    OPD_IDLE,
    OPD_PORT_IN,
    OPD_SW_INT,
    OPD_ACC_SHIFTED,
    OPD_ACC_LONG,
    OPD_ACC_HIGH_ZERO_LOW,
    OPD_ACC_SHORT,
    OPD_ACC_LOW,
    OPD_ACC_TEMP_SHIFT,
    OPD_AUX_DIRECT,
    OPD_AUX_SHORT,
    OPD_AUX_LONG,
    OPD_PAGE_MEM,
    OPD_PAGE_IMM,
    OPD_STATUS_ZERO,
    OPD_STATUS_ONE,
    OPD_TEMP_LOAD,
    OPD_TEMP_LOAD_ACC
  } opd_class_t;

  typedef enum {
    OPD_ST_HALT,
    OPD_ST_FETCH1,
    OPD_ST_FETCH2,
    OPD_ST_EXEC,
    OPD_ST_STALL
  } opd_state_t;

  typedef struct packed {
    opd_class_t cls;
    logic twoWords;
    logic conditional;
    logic [2:0] costTaken;
    logic [2:0] costNotTaken;
  } opd_decode_t;

endpackage

// file: opd_decoder_assertions.sv
`timescale 1ns/1ps
module opd_decoder_checker
  import opd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fetchReq_q,
  input wire logic fetchValid,
  input wire logic execPulse_q,
  input wire opd_class_t opClass_q,
  input wire logic [15:0] operandWord_q,
  input wire logic condMet_q,
  input wire logic [2:0] cycleCost_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic fetchTake;
  assign fetchTake = fetchReq_q && fetchValid;
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_pulseEnd;
    execPulse_q ##1 !execPulse_q;
  endsequence
  sequence s_dec(opd_class_t c);
    execPulse_q && (opClass_q == c);
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_branchCost;
    s_dec(OPD_COND_BRANCH) |-> cycleCost_q == (condMet_q ? 3'h4 : 3'h2);
  endproperty
  a_branchCost: assert property (p_branchCost) else $error("branch cost wrong");
  property p_blockCost;
    execPulse_q && (opClass_q inside {OPD_BLK_DD_SRC, OPD_BLK_DD_DST, OPD_BLK_PD}) |-> cycleCost_q == 3'h3;
  endproperty
  a_blockCost: assert property (p_blockCost) else $error("block move cost wrong");
  property p_portIn;
    s_dec(OPD_PORT_IN) |-> cycleCost_q == 3'h2;
  endproperty
  a_portIn: assert property (p_portIn) else $error("port input cost wrong");
  property p_accLong;
    s_dec(OPD_ACC_LONG) |-> cycleCost_q == 3'h2;
  endproperty
  a_accLong: assert property (p_accLong) else $error("long load cost wrong");
  property p_twoCycle;
    execPulse_q && (opClass_q inside {OPD_AUX_DIRECT, OPD_AUX_SHORT, OPD_AUX_LONG, OPD_PAGE_MEM,
      OPD_PAGE_IMM, OPD_STATUS_ZERO, OPD_STATUS_ONE}) |-> cycleCost_q == 3'h2;
  endproperty
  a_twoCycle: assert property (p_twoCycle) else $error("two-cycle load cost wrong");
  property p_oneCycle;
    execPulse_q && (opClass_q inside {OPD_PROBE, OPD_REG_PROBE, OPD_FLAG_CLEAR, OPD_AUX_COMPARE,
      OPD_DATA_COPY, OPD_ACC_SHIFTED, OPD_ACC_HIGH_ZERO_LOW, OPD_ACC_SHORT, OPD_ACC_LOW,
      OPD_ACC_TEMP_SHIFT, OPD_TEMP_LOAD, OPD_TEMP_LOAD_ACC}) |-> cycleCost_q == 3'h1 && operandWord_q == 16'h0000;
  endproperty
  a_oneCycle: assert property (p_oneCycle) else $error("one-word decode wrong");
  property p_execAfterTake;
    execPulse_q |-> $past(fetchTake, 2);
  endproperty
  a_execAfterTake: assert property (p_execAfterTake) else $error("decode without fetched word");
  property p_execSingle;
    $rose(execPulse_q) |-> s_pulseEnd;
  endproperty
  a_execSingle: assert property (p_execSingle) else $error("decode pulse too long");
  property p_fetchStands;
    fetchReq_q && !fetchValid |=> fetchReq_q;
  endproperty
  a_fetchStands: assert property (p_fetchStands) else $error("fetch request dropped");
  property p_stallTwo;
    execPulse_q && cycleCost_q >= 3'h2 |-> !fetchReq_q [*2];
  endproperty
  a_stallTwo: assert property (p_stallTwo) else $error("fetch resumed before cost elapsed");
  property p_stallFour;
    execPulse_q && cycleCost_q == 3'h4 |-> !fetchReq_q [*4];
  endproperty
  a_stallFour: assert property (p_stallFour) else $error("fetch resumed before branch cost elapsed");
endmodule

bind opd_decoder opd_decoder_checker u_chk (
  .sys_clk(sys_clk),
  .rstn(rstn),
  .fetchReq_q(fetchReq_q),
  .fetchValid(fetchValid),
  .execPulse_q(execPulse_q),
  .opClass_q(opClass_q),
  .operandWord_q(operandWord_q),
  .condMet_q(condMet_q),
  .cycleCost_q(cycleCost_q)
);

// file: opd_fetch_mem.sv
`timescale 1ns/1ps
module opd_fetch_mem #(
  parameter int ADDR_W = 16,
  parameter int LAT = 2
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fetchReq,
  input wire logic [ADDR_W-1:0] fetchAddr,
  output logic fetchValid,
  output logic [15:0] fetchWord
);
  logic [15:0] mem [0:255];
  logic [15:0] lastWord_q;
  logic [3:0] wait_q;
  // Waits LAT cycles per word, so the lagging fetch address has settled
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 4'h0;
      lastWord_q <= 16'h0000;
    end else if (fetchValid) begin
      wait_q <= 4'h0;
      lastWord_q <= fetchWord;
    end else if (fetchReq && wait_q < 4'(LAT)) begin
      wait_q <= wait_q + 4'h1;
    end
  end
  assign fetchValid = fetchReq && (wait_q == 4'(LAT));
  // Idle bus shows the inverse of the last word, never a stale copy
  assign fetchWord = fetchValid ? mem[8'(fetchAddr)] : ~lastWord_q;
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`include "opd_params.svh"
module tb_top
  import opd_pkg::*;
;
  logic sys_clk, rstn, wbCyc, wbStb, wbWe, wbAck, fetchReq, fetchValid, execPulse;
  logic accZero, accNeg, overflowFlag, carryFlag, testControlFlag, branchInputPin, useTempShift, condMet;
  logic [7:0] wbAdr, shortConstant;
  logic [3:0] wbSel, shiftCount, probeIndex, flagSelect;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [15:0] fetchAddr, fetchWord, operandWord, pc;
  logic [2:0] auxSelect, cycleCost;
  logic [1:0] compareKind;
  opd_class_t opClass;
  opd_class_t eCls [64];
  logic [15:0] eOp [64];
  logic [2:0] eCost [64];
  logic [2:0] eSel [64];
  logic [7:0] eFld [64];
  logic eCond [64];
  int nExp, nSeen, miscompares, nTests, n;
  opd_decoder i_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .fetchReq_q(fetchReq), .fetchAddr_q(fetchAddr), .fetchValid(fetchValid), .fetchWord(fetchWord),
    .accZero(accZero), .accNeg(accNeg), .overflowFlag(overflowFlag), .carryFlag(carryFlag),
    .testControlFlag(testControlFlag), .branchInputPin(branchInputPin), .execPulse_q(execPulse),
    .opClass_q(opClass), .operandWord_q(operandWord), .shortConstant_q(shortConstant),
    .shiftCount_q(shiftCount), .probeIndex_q(probeIndex), .auxSelect_q(auxSelect),
    .compareKind_q(compareKind), .flagSelect_q(flagSelect), .useTempShift_q(useTempShift),
    .condMet_q(condMet), .cycleCost_q(cycleCost));
  opd_fetch_mem i_mem (.sys_clk(sys_clk), .rstn(rstn), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchValid(fetchValid), .fetchWord(fetchWord));
  always #2.5 sys_clk = ~sys_clk;
  // Toggling sign flag must not disturb branches that mask it out
  always @(posedge sys_clk) accNeg <= ~accNeg;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  task wrapUp();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Request stands until ack is sampled at a rising edge; data is taken and the request dropped there
  task wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    if (wbAck !== 1'b1) miscompares++;
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task put(input logic [15:0] w, input logic [15:0] op, input opd_class_t c, input logic [2:0] cost,
    input logic [2:0] sel, input logic [7:0] fld);
    if (op === 16'hffff) op = pc + 16'h0002;
    i_mem.mem[pc[7:0]] = w;
    if (op !== 16'h0000) i_mem.mem[pc[7:0] + 8'h01] = op;
    eCls[nExp] = c;
    eOp[nExp] = op;
    eCost[nExp] = cost;
    eSel[nExp] = sel;
    eFld[nExp] = fld;
    eCond[nExp] = (c == OPD_COND_BRANCH) ? (cost == 3'h4) : 1'b1;
    nExp++;
    pc = pc + ((op !== 16'h0000) ? 16'h0002 : 16'h0001);
  endtask
  function automatic logic [7:0] fieldOf(input logic [2:0] s);
    case (s)
      3'h1: return {4'h0, probeIndex};
      3'h2: return {4'h0, flagSelect};
      3'h3: return {6'h00, compareKind};
      3'h4: return {4'h0, shiftCount};
      3'h5: return shortConstant;
      3'h6: return {5'h00, auxSelect};
      3'h7: return {7'h00, useTempShift};
      default: return 8'h00;
    endcase
  endfunction
  always @(negedge sys_clk) begin
    if (rstn === 1'b1 && execPulse === 1'b1 && nSeen < nExp) begin
      chk("class", 32'(eCls[nSeen]), 32'(opClass));
      chk("cost", {29'h0, eCost[nSeen]}, {29'h0, cycleCost});
      chk("operand", {16'h0, eOp[nSeen]}, {16'h0, operandWord});
      chk("condition", {31'h0, eCond[nSeen]}, {31'h0, condMet});
      chk("field", {24'h0, eFld[nSeen]}, {24'h0, fieldOf(eSel[nSeen])});
      nSeen++;
    end
  end
  initial begin
    #200000;
    miscompares++;
    wrapUp();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {wbCyc, wbStb, wbWe, accZero, accNeg, overflowFlag, carryFlag, testControlFlag} = 8'h00;
    branchInputPin = 1'b1;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    wbDatI = 32'h0;
    {nExp, nSeen, miscompares, nTests, pc} = '0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    wbXfer(1'b0, `OPD_REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    wbXfer(1'b0, `OPD_REG_PC, 32'h0);
    chk("pc reset", 32'h0, rd);
    wbXfer(1'b1, 8'h40, 32'hffffffff);
    wbXfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (n = 0; n < 256; n++) i_mem.mem[n] = 16'hbe41;
    put(16'he308, 16'hffff, OPD_COND_BRANCH, 3'h4, 3'h0, 8'h00);
    put(16'he388, 16'hffff, OPD_COND_BRANCH, 3'h2, 3'h0, 8'h00);
    put(16'he322, 16'hffff, OPD_COND_BRANCH, 3'h2, 3'h0, 8'h00);
    put(16'h4a12, 16'h0000, OPD_PROBE, 3'h1, 3'h1, 8'h0a);
    put(16'h6f05, 16'h0000, OPD_REG_PROBE, 3'h1, 3'h7, 8'h01);
    put(16'ha812, 16'h1234, OPD_BLK_DD_SRC, 3'h3, 3'h0, 8'h00);
    put(16'ha913, 16'h0300, OPD_BLK_DD_DST, 3'h3, 3'h0, 8'h00);
    put(16'ha512, 16'h2000, OPD_BLK_PD, 3'h3, 3'h0, 8'h00);
    for (n = 0; n < 7; n++) begin
      put({12'hbe4, 4'(28'h40e26ac >> (24 - 4 * n))}, 16'h0000, OPD_FLAG_CLEAR, 3'h1, 3'h2,
        {4'h0, 4'(28'h40e26ac >> (24 - 4 * n))});
    end
    put(16'hbe41, 16'h0000, OPD_NONE, 3'h1, 3'h0, 8'h00);
    put(16'hbf46, 16'h0000, OPD_AUX_COMPARE, 3'h1, 3'h3, 8'h02);
    put(16'h7712, 16'h0000, OPD_DATA_COPY, 3'h1, 3'h0, 8'h00);
    put(16'haf12, 16'hfedc, OPD_PORT_IN, 3'h2, 3'h0, 8'h00);
    put(16'h1c12, 16'h0000, OPD_ACC_SHIFTED, 3'h1, 3'h4, 8'h0c);
    put(16'hbf87, 16'h8001, OPD_ACC_LONG, 3'h2, 3'h4, 8'h07);
    put(16'h6a12, 16'h0000, OPD_ACC_HIGH_ZERO_LOW, 3'h1, 3'h0, 8'h00);
    put(16'hb900, 16'h0000, OPD_ACC_SHORT, 3'h1, 3'h5, 8'h00);
    put(16'hb9a5, 16'h0000, OPD_ACC_SHORT, 3'h1, 3'h5, 8'ha5);
    put(16'h6912, 16'h0000, OPD_ACC_LOW, 3'h1, 3'h0, 8'h00);
    put(16'h6b12, 16'h0000, OPD_ACC_TEMP_SHIFT, 3'h1, 3'h7, 8'h01);
    put(16'h0312, 16'h0000, OPD_AUX_DIRECT, 3'h2, 3'h6, 8'h03);
    put(16'hb5ff, 16'h0000, OPD_AUX_SHORT, 3'h2, 3'h6, 8'h05);
    put(16'hbf0e, 16'h4321, OPD_AUX_LONG, 3'h2, 3'h6, 8'h06);
    put(16'h0d12, 16'h0000, OPD_PAGE_MEM, 3'h2, 3'h0, 8'h00);
    put(16'hbd12, 16'h0000, OPD_PAGE_IMM, 3'h2, 3'h0, 8'h00);
    put(16'h0e12, 16'h0000, OPD_STATUS_ZERO, 3'h2, 3'h0, 8'h00);
    put(16'h0f12, 16'h0000, OPD_STATUS_ONE, 3'h2, 3'h0, 8'h00);
    put(16'he000, 16'hffff, OPD_COND_BRANCH, 3'h2, 3'h0, 8'h00);
    put(16'he200, 16'hffff, OPD_COND_BRANCH, 3'h4, 3'h0, 8'h00);
    put(16'heb00, 16'hffff, OPD_COND_CALL, 3'h4, 3'h0, 8'h00);
    put(16'h7a12, 16'hffff, OPD_CALL, 3'h4, 3'h0, 8'h00);
    put(16'hbe30, 16'h0000, OPD_CALL_INDIRECT, 3'h4, 3'h0, 8'h00);
    put(16'hbe65, 16'h0000, OPD_SW_INT, 3'h4, 3'h0, 8'h00);
    put(16'hbe22, 16'h0000, OPD_IDLE, 3'h1, 3'h0, 8'h00);
    put(16'h7312, 16'h0000, OPD_TEMP_LOAD, 3'h1, 3'h0, 8'h00);
    put(16'h7012, 16'h0000, OPD_TEMP_LOAD_ACC, 3'h1, 3'h0, 8'h00);
    wbXfer(1'b1, `OPD_REG_PC, 32'h0);
    wbXfer(1'b1, `OPD_REG_CTRL, 32'h1);
    n = 0;
    while (nSeen < nExp && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    wbXfer(1'b1, `OPD_REG_CTRL, 32'h0);
    repeat (20) @(posedge sys_clk);
    wbXfer(1'b0, `OPD_REG_STATUS, 32'h0);
    chk("busy", 32'h0, {31'h0, rd[`OPD_STAT_BUSY_BIT]});
    chk("status class", 32'(OPD_NONE), {27'h0, rd[`OPD_STAT_CLASS_LSB +: 5]});
    chk("status cost", 32'h1, {29'h0, rd[`OPD_STAT_COST_LSB +: 3]});
    wbXfer(1'b1, `OPD_REG_COUNT, 32'h0);
    wbXfer(1'b0, `OPD_REG_COUNT, 32'h0);
    chk("count cleared", 32'h0, rd);
    chk("decodes", 32'(nExp), 32'(nSeen));
    wrapUp();
  end
endmodule
